// [core/hbi_host_bus_interface.sv]
// host parallel bus front end: style select, access decode, interrupt pin and reset
//
// Design decisions made here: the plain strobed port and the register addresses.
`timescale 1ns/10ps
module hbi_host_bus_interface (
  input  wire logic                          i_sys_clk,
  input  wire logic                          i_rst,
  input  wire logic                          i_mux_bus_select,
  input  wire logic                          i_strobe_style,
  input  wire logic                          i_reset_pin,
  input  wire logic                          i_chip_select_n,
  input  wire logic                          i_read_strobe_n,
  input  wire logic                          i_write_strobe_n,
  input  wire logic                          i_address_latch_n,
  input  wire logic [1:0]                    i_register_index_hi,
  input  wire logic [hbi_pkg::DATA_W-1:0]    i_shared_addr_data,
  output logic      [hbi_pkg::DATA_W-1:0]    o_shared_addr_data,
  output logic                               o_shared_addr_data_oe_n,
  output logic                               o_irq,
  output logic                               o_irq_oe_n,
  input  wire logic                          i_irq_request,
  input  wire logic                          i_serial_rx,
  output logic                               o_serial_tx,
  output logic                               o_serial_rx_seen,
  output logic                               o_access_valid,
  output hbi_pkg::hbi_access_t               o_access
);
  // two-stage synchronisers; stage one is read only by stage two
  localparam int unsigned NSYNC = 16;
  logic [NSYNC-1:0] sync1;
  logic [NSYNC-1:0] sync2;
  logic [NSYNC-1:0] sync_in;

  assign sync_in = {i_mux_bus_select, i_strobe_style, i_reset_pin, i_chip_select_n,
                    i_read_strobe_n, i_write_strobe_n, i_address_latch_n, i_register_index_hi,
                    i_serial_rx, 6'h00};

  always_ff @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      sync1 <= 16'hFFFF;
      sync2 <= 16'hFFFF;
    end else begin
      sync1 <= sync_in;
      sync2 <= sync1;
    end
  end

  logic mux_sel;
  logic style_sel;
  logic rst_pin;
  logic cs_n;
  logic rd_n;
  logic wr_n;
  logic ale_n;
  logic [1:0] idx_hi;
  logic rx_s;
  assign mux_sel   = sync2[15];
  assign style_sel = sync2[14];
  assign rst_pin   = sync2[13];
  assign cs_n      = sync2[12];
  assign rd_n      = sync2[11];
  assign wr_n      = sync2[10];
  assign ale_n     = sync2[9];
  assign idx_hi    = sync2[8:7];
  assign rx_s      = sync2[6];

  // data bus sampled twice as well
  logic [7:0] bus1;
  logic [7:0] bus2;
  always_ff @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      bus1 <= 8'h00;
      bus2 <= 8'h00;
    end else begin
      bus1 <= i_shared_addr_data;
      bus2 <= bus1;
    end
  end

  hbi_pkg::hbi_style_t style;
  always_comb begin
    if (mux_sel) begin
      style = hbi_pkg::HBI_STYLE_MUX;
    end else if (style_sel) begin
      style = hbi_pkg::HBI_STYLE_STROBES;
    end else begin
      style = hbi_pkg::HBI_STYLE_RW_LINE;
    end
  end

  // pin reset polarity follows the strobe-style strap
  logic pin_reset;
  assign pin_reset = style_sel ? rst_pin : !rst_pin;

  // register pin reset so the core stays in reset for its whole active time, one cycle late
  logic core_rst;
  always_ff @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      core_rst <= 1'b1;
    end else begin
      core_rst <= pin_reset;
    end
  end

  logic [3:0] prev;
  always_ff @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      prev <= 4'hF;
    end else begin
      prev <= {cs_n, rd_n, wr_n, ale_n};
    end
  end
  logic cs_fall;
  logic rd_fall;
  logic rd_rise;
  logic wr_rise;
  logic ale_rise;
  logic cs_rise;
  assign cs_fall  = prev[3] && !cs_n;
  assign cs_rise  = !prev[3] && cs_n;
  assign rd_fall  = prev[2] && !rd_n;
  assign rd_rise  = !prev[2] && rd_n;
  assign wr_rise  = !prev[1] && wr_n;
  assign ale_rise = !prev[0] && ale_n;

  // access state: started by chip select in multiplexed style
  logic       in_access;
  logic       data_phase;
  logic [2:0] latched_idx;
  always_ff @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      in_access   <= 1'b0;
      data_phase  <= 1'b0;
      latched_idx <= 3'h0;
    end else if (core_rst) begin
      in_access   <= 1'b0;
      data_phase  <= 1'b0;
      latched_idx <= 3'h0;
    end else if (cs_fall) begin
      in_access   <= 1'b1;
      data_phase  <= 1'b0;
    end else if (cs_rise) begin
      in_access   <= 1'b0;
      data_phase  <= 1'b0;
    end else if (ale_rise && in_access && style == hbi_pkg::HBI_STYLE_MUX) begin
      latched_idx <= bus2[2:0];
      data_phase  <= 1'b1;
    end
  end

  logic [2:0] direct_idx;
  assign direct_idx = {idx_hi, ale_n};

  logic [2:0] eff_idx;
  assign eff_idx = (style == hbi_pkg::HBI_STYLE_MUX) ? latched_idx : direct_idx;

  logic mux_ok;
  assign mux_ok = in_access && data_phase;

  // read and write decode per style
  logic do_read;
  logic do_write;
  logic rd_active;
  always_comb begin
    do_read   = 1'b0;
    do_write  = 1'b0;
    rd_active = 1'b0;
    case (style)
      hbi_pkg::HBI_STYLE_MUX: begin
        do_read   = mux_ok && rd_fall;
        do_write  = mux_ok && wr_rise;
        rd_active = mux_ok && !rd_n;
      end
      hbi_pkg::HBI_STYLE_STROBES: begin
        do_read   = !cs_n && rd_fall;
        do_write  = !cs_n && wr_rise;
        rd_active = !cs_n && !rd_n;
      end
      hbi_pkg::HBI_STYLE_RW_LINE: begin
        do_read   = cs_fall && wr_n;
        do_write  = cs_rise && !prev[1];
        rd_active = !cs_n && wr_n;
      end
      default: begin
        do_read   = 1'b0;
      end
    endcase
  end

  logic       rf_we;
  logic [7:0] rf_rdata;
  logic       irq_oe_bit;
  assign rf_we = do_write && !core_rst;

  hbi_regfile u_regs (
    .i_sys_clk    (i_sys_clk),
    .i_rst        (i_rst || core_rst),
    .i_we         (rf_we),
    .i_waddr      (eff_idx),
    .i_wdata      (bus2),
    .i_re         (do_read),
    .i_raddr      (eff_idx),
    .o_rdata      (rf_rdata),
    .o_irq_oe_bit (irq_oe_bit)
  );

  always_ff @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      o_access_valid <= 1'b0;
      o_access       <= '0;
    end else if (core_rst) begin
      o_access_valid <= 1'b0;
      o_access       <= '0;
    end else begin
      o_access_valid <= do_read || do_write;
      if (do_read || do_write) begin
        o_access <= '{write: do_write, index: eff_idx, data: do_write ? bus2 : 8'h00};
      end
    end
  end

  // read data drive, enable active low
  always_ff @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      o_shared_addr_data_oe_n <= 1'b1;
    end else begin
      o_shared_addr_data_oe_n <= !(rd_active && !core_rst);
    end
  end
  assign o_shared_addr_data = rf_rdata;

  // interrupt pin by style
  always_ff @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      o_irq      <= 1'b0;
      o_irq_oe_n <= 1'b1;
    end else if (core_rst) begin
      o_irq      <= 1'b0;
      o_irq_oe_n <= 1'b1;
    end else if (style == hbi_pkg::HBI_STYLE_RW_LINE) begin
      o_irq      <= 1'b0;
      o_irq_oe_n <= !i_irq_request;
    end else begin
      o_irq      <= i_irq_request;
      o_irq_oe_n <= !irq_oe_bit;
    end
  end

  // serial side during reset
  always_ff @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      o_serial_tx      <= 1'b1;
      o_serial_rx_seen <= 1'b1;
    end else begin
      o_serial_tx      <= 1'b1;
      o_serial_rx_seen <= core_rst ? 1'b1 : rx_s;
    end
  end

  // access steps as the core sees them once the pins are synchronised
  sequence mux_addr_phase_s;
    style == hbi_pkg::HBI_STYLE_MUX && in_access && ale_rise && !cs_rise && !cs_fall;
  endsequence
  sequence mux_data_phase_s;
    data_phase && latched_idx == $past(bus2[2:0]);
  endsequence
  sequence mux_read_start_s;
    style == hbi_pkg::HBI_STYLE_MUX && mux_ok && rd_fall && !wr_rise;
  endsequence
  sequence rw_write_end_s;
    style == hbi_pkg::HBI_STYLE_RW_LINE && cs_rise && !prev[1];
  endsequence

  tx_reset_a: assert property (@(posedge i_sys_clk) disable iff (i_rst)
    core_rst |=> o_serial_tx) else $error("tx not high in reset");
  irq_od_a: assert property (@(posedge i_sys_clk) disable iff (i_rst)
    (style == hbi_pkg::HBI_STYLE_RW_LINE && !core_rst) |=> !o_irq) else $error("open drain drove high");
  irq_oe_a: assert property (@(posedge i_sys_clk) disable iff (i_rst)
    (style == hbi_pkg::HBI_STYLE_STROBES && !core_rst && !irq_oe_bit) |=> o_irq_oe_n)
    else $error("irq driven while disabled");
  rst_pol_a: assert property (@(posedge i_sys_clk) disable iff (i_rst)
    (style_sel == rst_pin) |=> core_rst) else $error("reset polarity wrong");
  addr_latch_a: assert property (@(posedge i_sys_clk) disable iff (i_rst || core_rst)
    mux_addr_phase_s |=> mux_data_phase_s) else $error("address not latched");
  mux_gate_a: assert property (@(posedge i_sys_clk) disable iff (i_rst)
    (style == hbi_pkg::HBI_STYLE_MUX && !data_phase) |-> !rf_we) else $error("write before data phase");
  direct_idx_a: assert property (@(posedge i_sys_clk) disable iff (i_rst)
    style != hbi_pkg::HBI_STYLE_MUX |-> eff_idx == {idx_hi, ale_n}) else $error("direct index wrong");
  mux_pri_a: assert property (@(posedge i_sys_clk) disable iff (i_rst)
    mux_sel |-> style == hbi_pkg::HBI_STYLE_MUX) else $error("mux strap ignored");

  // reset values, bus release after a read, and the two committed-access paths
  mux_read_a: assert property (@(posedge i_sys_clk) disable iff (i_rst || core_rst)
    mux_read_start_s |=> !o_shared_addr_data_oe_n && o_access_valid && !o_access.write
    && o_access.index == $past(latched_idx))
    else $error("multiplexed read not taken");
  rw_write_a: assert property (@(posedge i_sys_clk) disable iff (i_rst || core_rst)
    rw_write_end_s |=> o_access_valid && o_access.write && o_access.data == $past(bus2)
    && o_access.index == $past(direct_idx))
    else $error("direction line write not taken");
  rst_out_a: assert property (@(posedge i_sys_clk) disable iff (i_rst)
    core_rst |=> o_shared_addr_data_oe_n && o_irq_oe_n && !o_irq && !o_access_valid && o_serial_rx_seen)
    else $error("outputs not at reset values");
  rd_release_a: assert property (@(posedge i_sys_clk) disable iff (i_rst)
    (style != hbi_pkg::HBI_STYLE_RW_LINE && rd_rise) |=> o_shared_addr_data_oe_n)
    else $error("bus still driven after read");
endmodule // hbi_host_bus_interface

// [core/hbi_pkg.sv]
// constants and carrier types for the host bus interface
package hbi_pkg;
  localparam int unsigned CLK_PERIOD_NS   = 40;
  localparam int unsigned RST_MIN_NS      = 40;
  localparam int unsigned RST_MIN_CYC     = (RST_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned DATA_W          = 8;
  localparam int unsigned IDX_W           = 3;
  localparam int unsigned NUM_REGS        = 8;
  localparam logic [7:0]  REG_RESET_VALUE = 8'h00;
  localparam int unsigned IRQ_OE_BIT_POS  = 3;
  localparam logic [2:0]  IRQ_CTRL_INDEX  = 3'h4;

  typedef enum logic [1:0] {
    HBI_STYLE_STROBES,
    HBI_STYLE_RW_LINE,
    HBI_STYLE_MUX
  } hbi_style_t;

  typedef struct packed {
    logic                  write;
    logic [IDX_W-1:0]      index;
    logic [DATA_W-1:0]     data;
  } hbi_access_t;
endpackage

// [core/hbi_regfile.sv]
// eight-byte register store with registered read data
`timescale 1ns/10ps
module hbi_regfile (
  input  wire logic                          i_sys_clk,
  input  wire logic                          i_rst,
  input  wire logic                          i_we,
  input  wire logic [hbi_pkg::IDX_W-1:0]     i_waddr,
  input  wire logic [hbi_pkg::DATA_W-1:0]    i_wdata,
  input  wire logic                          i_re,
  input  wire logic [hbi_pkg::IDX_W-1:0]     i_raddr,
  output logic      [hbi_pkg::DATA_W-1:0]    o_rdata,
  output logic                               o_irq_oe_bit
);
  logic [hbi_pkg::DATA_W-1:0] mem [hbi_pkg::NUM_REGS];

  always_ff @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      for (int i = 0; i < hbi_pkg::NUM_REGS; i++) begin
        mem[i] <= hbi_pkg::REG_RESET_VALUE;
      end
    end else if (i_we) begin
      mem[i_waddr] <= i_wdata;
    end
  end

  always_ff @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      o_rdata <= hbi_pkg::REG_RESET_VALUE;
    end else if (i_re) begin
      o_rdata <= mem[i_raddr];
    end
  end

  assign o_irq_oe_bit = mem[hbi_pkg::IRQ_CTRL_INDEX][hbi_pkg::IRQ_OE_BIT_POS];
endmodule // hbi_regfile

// [testbench/hbi_host_model.sv]
// host processor model driving the parallel bus pins
`timescale 1ns/10ps
module hbi_host_model (
  input  wire logic       i_clk,
  input  wire logic [7:0] i_bus,
  output logic            o_cs_n,
  output logic            o_rd_n,
  output logic            o_wr_n,
  output logic            o_ale_n,
  output logic [1:0]      o_idx_hi,
  output logic [7:0]      o_ad
);
  initial begin
    {o_cs_n, o_rd_n, o_wr_n, o_ale_n, o_idx_hi, o_ad} = 14'h3C00;
  end

  task automatic step(input int n);
    repeat (n) @(posedge i_clk);
  endtask

  // md: 2 multiplexed, 1 read/write line, 0 separate strobes
  task automatic xfer(input int md, input logic wr, input logic [2:0] idx, input logic [7:0] d,
                      output logic [7:0] q);
    if (md == 2) begin
      o_cs_n <= 1'b0;
      step(4);
      o_ad <= {5'h00, idx};
      o_ale_n <= 1'b0;
      step(4);
      o_ale_n <= 1'b1;
      step(4);
      // released lines show the inverse so a stale byte never passes
      o_ad <= wr ? d : ~o_ad;
    end else begin
      o_ale_n <= idx[0];
      o_idx_hi <= idx[2:1];
      o_wr_n <= (md == 1) ? !wr : 1'b1;
      o_ad <= wr ? d : ~o_ad;
      step(4);
      o_cs_n <= 1'b0;
    end
    if (md != 1) begin
      step(4);
      if (wr) o_wr_n <= 1'b0;
      else o_rd_n <= 1'b0;
    end
    step(8);
    q = i_bus;
    if (md != 1) begin
      o_rd_n <= 1'b1;
      o_wr_n <= 1'b1;
      step(4);
    end
    o_cs_n <= 1'b1;
    step(6);
    o_ad <= ~o_ad;
    o_wr_n <= 1'b1;
    step(2);
  endtask
endmodule // hbi_host_model

// [testbench/tb_hbi_host_bus_interface.sv]
// self-checking bench for the host bus interface
`timescale 1ns/10ps
module tb_hbi_host_bus_interface;
  logic                 clk, rst, mux_sel, sstyle, rpin, irq_req, rx;
  logic                 cs_n, rd_n, wr_n, ale_n, dev_oe_n, irq, irq_oe_n, tx, rx_seen, valid;
  logic [1:0]           idx_hi;
  logic [7:0]           host_ad, dev_ad, q;
  logic [7:0]           mem [8];
  wire  [7:0]           bus = dev_oe_n ? host_ad : dev_ad;
  hbi_pkg::hbi_access_t acc, ex;
  hbi_pkg::hbi_access_t expq [$];
  int                   fail_count, comparisons, seed;

  hbi_host_bus_interface u_hbi_host_bus_interface (
    .i_sys_clk(clk), .i_rst(rst), .i_mux_bus_select(mux_sel), .i_strobe_style(sstyle),
    .i_reset_pin(rpin), .i_chip_select_n(cs_n), .i_read_strobe_n(rd_n), .i_write_strobe_n(wr_n),
    .i_address_latch_n(ale_n), .i_register_index_hi(idx_hi), .i_shared_addr_data(bus),
    .o_shared_addr_data(dev_ad), .o_shared_addr_data_oe_n(dev_oe_n), .o_irq(irq), .o_irq_oe_n(irq_oe_n),
    .i_irq_request(irq_req), .i_serial_rx(rx), .o_serial_tx(tx), .o_serial_rx_seen(rx_seen),
    .o_access_valid(valid), .o_access(acc));

  hbi_host_model u_hbi_host_model (
    .i_clk(clk), .i_bus(bus), .o_cs_n(cs_n), .o_rd_n(rd_n), .o_wr_n(wr_n),
    .o_ale_n(ale_n), .o_idx_hi(idx_hi), .o_ad(host_ad));

  initial begin
    clk = 1'b0;
    forever #(hbi_pkg::CLK_PERIOD_NS / 2) clk = ~clk;
  end

  task automatic chk(input logic [7:0] g, input logic [7:0] e, input string m);
    comparisons++;
    if (g !== e) begin
      fail_count++;
      $display("MISMATCH %0t %s got %h exp %h", $time, m, g, e);
    end
  endtask

  task automatic chk_acc(input hbi_pkg::hbi_access_t g, input hbi_pkg::hbi_access_t e);
    chk({g.write, 4'h0, g.index}, {e.write, 4'h0, e.index}, "access kind");
    if (e.write) chk(g.data, e.data, "access data");
  endtask

  // results appear as pulses; pair each with the oldest note
  always @(negedge clk) begin
    if (valid === 1'b1) begin
      if (expq.size() == 0) chk(8'h01, 8'h00, "unexpected access");
      else begin
        ex = expq.pop_front();
        chk_acc(acc, ex);
      end
    end
  end

  task automatic op(input int md, input logic wr, input logic [2:0] i, input logic [7:0] d);
    expq.push_back({wr, i, d});
    u_hbi_host_model.xfer(md, wr, i, d, q);
    if (wr) mem[i] = d;
    else chk(q, mem[i], "read data");
  endtask

  task automatic sweep(input int md);
    for (int k = 0; k < 8; k++) op(md, 1'b1, 3'(k), 8'($random(seed)));
    for (int k = 0; k < 8; k++) op(md, 1'b0, 3'(k), 8'h00);
  endtask

  task automatic irq_chk(input logic req, input logic e_irq, input logic e_oe_n);
    irq_req <= req;
    repeat (5) @(posedge clk);
    chk({7'h00, irq}, {7'h00, e_irq}, "irq level");
    chk({7'h00, irq_oe_n}, {7'h00, e_oe_n}, "irq enable");
  endtask

  task automatic set_mode(input logic m, input logic s);
    mux_sel <= m;
    sstyle <= s;
    rpin <= ~s;
    repeat (8) @(posedge clk);
  endtask

  task automatic wrap_up();
    if (expq.size() != 0) fail_count++;
    $display("comparisons %0d fail_count %0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask

  initial begin
    #(hbi_pkg::CLK_PERIOD_NS * 20000);
    fail_count++;
    wrap_up();
  end

  initial begin
    seed = 18;
    {rst, mux_sel, sstyle, rpin, irq_req, rx} = 6'b111001;
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    repeat (4) @(posedge clk);
    for (int s = 1; s >= 0; s--) begin
      set_mode(1'b1, s[0]);
      sweep(2);
      $display("test multiplexed %0d done", s);
    end
    set_mode(1'b0, 1'b1);
    sweep(0);
    op(0, 1'b1, hbi_pkg::IRQ_CTRL_INDEX, 8'h08);
    irq_chk(1'b1, 1'b1, 1'b0);
    irq_chk(1'b0, 1'b0, 1'b0);
    op(0, 1'b1, hbi_pkg::IRQ_CTRL_INDEX, 8'h00);
    irq_chk(1'b1, 1'b1, 1'b1);
    irq_chk(1'b0, 1'b0, 1'b1);
    $display("test strobes done");
    set_mode(1'b0, 1'b0);
    sweep(1);
    irq_chk(1'b1, 1'b0, 1'b0);
    irq_chk(1'b0, 1'b0, 1'b1);
    $display("test direction line done");
    rx <= 1'b0;
    repeat (5) @(posedge clk);
    chk({7'h00, rx_seen}, 8'h00, "rx follows");
    for (int s = 0; s < 2; s++) begin
      op(s ? 0 : 1, 1'b1, 3'h2, 8'h5A);
      rpin <= s[0];
      repeat (hbi_pkg::RST_MIN_CYC + 4) @(posedge clk);
      chk({6'h00, tx, rx_seen}, 8'h03, "serial in reset");
      rpin <= ~s[0];
      repeat (6) @(posedge clk);
      foreach (mem[k]) mem[k] = hbi_pkg::REG_RESET_VALUE;
      op(s ? 0 : 1, 1'b0, 3'h2, 8'h00);
      if (s == 0) set_mode(1'b0, 1'b1);
    end
    $display("test pin reset done");
    wrap_up();
  end
endmodule // tb_hbi_host_bus_interface
